// *** design/serial_unit_pkg.sv ***
/*
 * package for the serial unit select and baud divider block: register indices,
 * field layouts, reset values and the controller-select encoding.
 * assumes an apb slave with 32-bit data; printed offsets are register indices.
 */
package serial_unit_pkg;

    // printed offsets are not all multiples of four: kept as indices, byte address = 4 * index
    localparam logic [7:0]  idx_unit0_divisor_low       = 8'hc0; // shared with receive/transmit buffer
    localparam logic [7:0]  idx_unit0_divisor_high      = 8'hc1; // shared with interrupt enable
    localparam logic [7:0]  idx_unit0_line_control      = 8'hc3; // line control holding the access bit
    localparam logic [7:0]  idx_unit0_controller_select = 8'hcf;
    localparam logic [7:0]  idx_unit1_divisor_low       = 8'hd0;
    localparam logic [7:0]  idx_unit1_divisor_high      = 8'hd1;
    localparam logic [7:0]  idx_unit1_line_control      = 8'hd3;
    localparam logic [7:0]  idx_unit1_controller_select = 8'hdf;
    localparam logic [7:0]  idx_unit0_status            = 8'hce; // divider state readback
    localparam logic [7:0]  idx_unit1_status            = 8'hde;

    // field positions and reset values
    localparam int          divisor_access_bit   = 7;
    localparam logic [15:0] divisor_reset        = 16'h0002;
    localparam logic [15:0] divisor_terminal     = 16'h0001;
    localparam logic [7:0]  select_reset         = 8'h00;
    localparam logic [7:0]  line_control_reset   = 8'h00;

    // controller-select encoding
    typedef enum logic [1:0] {
        sel_none = 2'h0,
        sel_uart = 2'h1,
        sel_spi  = 2'h2,
        sel_twi  = 2'h3
    } controller_sel_t;

    // enables handed to the three controllers of one unit
    typedef struct packed {
        logic spi_en;      // spi controller enabled
        logic uart_en;     // uart controller enabled
        logic twi_en;      // two-wire controller enabled
        logic baud_tick;   // one-cycle clock enable for spi and uart
    } unit_enables_t;

endpackage

// *** design/baud_divider.sv ***
/*
 * one 16-bit reloading down-counter that yields a one-cycle end-of-count pulse for a divisor above 1.
 * assumes a single clock pclk with asynchronous active-low reset presetn.
 */
`timescale 1ns/10ps
module baud_divider #(
    parameter int width = 16                // counter width
) (
    input  wire logic             pclk,     // system clock
    input  wire logic             presetn,  // asynchronous reset, active low
    input  wire logic             active,   // unit selected; counter frozen otherwise, except that restart still reloads it
    input  wire logic             restart,  // divisor byte write: reload now
    input  wire logic [width-1:0] divisor,  // programmed divisor
    output logic      [width-1:0] count,    // current count
    output logic                  tick      // end-of-count pulse
);

    // counter: decrement to terminal, reload on the next edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= width'(serial_unit_pkg::divisor_reset);
        end else if (restart) begin
            count <= divisor;
        end else if (!active) begin
            count <= count;
        end else if (count <= width'(serial_unit_pkg::divisor_terminal)) begin
            count <= divisor; // also catches a zero divisor so it cannot wrap
        end else begin
            count <= count - width'(1);
        end
    end

    // pulse on the reload edge, exactly one cycle for a divisor above 1
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick <= 1'b0;
        end else begin
            tick <= active && !restart && (count <= width'(serial_unit_pkg::divisor_terminal));
        end
    end

    AST_TICK_ON_TERMINAL: assert property (@(posedge pclk) disable iff (!presetn)
        (active && !restart && count == width'(serial_unit_pkg::divisor_terminal)) |=> tick && count == $past(divisor))
        else $error("no reload pulse after terminal count");

    AST_DECREMENT: assert property (@(posedge pclk) disable iff (!presetn)
        (active && !restart && count > width'(1)) |=> count == $past(count) - width'(1) && !tick)
        else $error("counter did not decrement");

    AST_TICK_ONE_CYCLE: assert property (@(posedge pclk) disable iff (!presetn)
        tick && $past(divisor) > width'(1) |=> !tick)
        else $error("end-of-count pulse longer than one cycle");

    AST_INACTIVE_NO_TICK: assert property (@(posedge pclk) disable iff (!presetn)
        !active |=> !tick && count == $past(count) || $past(restart))
        else $error("divider ran while unit inactive");

endmodule

// *** design/serial_unit_select.sv ***
/*
 * two serial units, each with a controller-select register, a divisor-access
 * line control bit and a baud divider, reached over apb.
 * assumes one 100 MHz clock pclk, asynchronous active-low presetn, and that the
 * uart controllers' own buffer/interrupt-enable registers live behind uart ports here.
 */
// Implementation choice: register access over APB.
`timescale 1ns/10ps
module serial_unit_select #(
    parameter int units = 2                          // serial units in the block
) (
    input  wire logic                            pclk,          // system clock
    input  wire logic                            presetn,       // asynchronous reset, active low
    input  wire logic                            psel,          // apb select
    input  wire logic                            penable,       // apb access phase
    input  wire logic                            pwrite,        // apb direction
    input  wire logic [11:0]                     paddr,         // apb byte address
    input  wire logic [31:0]                     pwdata,        // apb write data
    output logic      [31:0]                     prdata,        // apb read data
    output logic                                 pready,        // apb ready
    output logic                                 pslverr,       // apb error
    input  wire logic [units-1:0][7:0]           uart_rdata_buf, // uart receive buffer contents
    input  wire logic [units-1:0][7:0]           uart_rdata_ier, // uart interrupt enable contents
    output logic      [units-1:0]                uart_buf_wr,   // write strobe to transmit holding
    output logic      [units-1:0]                uart_buf_rd,   // read strobe of receive buffer
    output logic      [units-1:0]                uart_ier_wr,   // write strobe to interrupt enable
    output logic      [7:0]                      uart_wdata,    // byte for the uart strobes
    output serial_unit_pkg::unit_enables_t [units-1:0] enables  // per-unit controller enables
);

    // apb access qualified at the access phase
    logic                   access;                 // access phase this cycle
    logic                   wr_acc;                 // write taking effect
    logic                   rd_acc;                 // read taking effect
    logic [9:0]             index;                  // register index = byte address / 4
    logic                   aligned;                // low address bits zero

    // per-unit state
    logic [units-1:0][7:0]  select_reg;             // controller-select registers
    logic [units-1:0][7:0]  line_control;           // line control incl. access bit
    logic [units-1:0][15:0] divisor;                // programmed divisors
    logic [units-1:0][15:0] count;                  // divider counts
    logic [units-1:0]       tick;                   // divider end-of-count
    logic [units-1:0]       restart;                // divisor byte written this cycle
    logic [units-1:0]       active;                 // unit selected

    // decoded hits per unit
    logic [units-1:0]       hit_low;                // low divisor / buffer address
    logic [units-1:0]       hit_high;               // high divisor / ier address
    logic [units-1:0]       hit_lctl;               // line control address
    logic [units-1:0]       hit_sel;                // controller-select address
    logic [units-1:0]       hit_stat;               // status address
    logic                   mapped;                 // any register hit

    // index of a register in a given unit; unit 1 sits 10h above unit 0
    function automatic logic [9:0] unit_index(input logic [7:0] base, input int u);
        unit_index = {2'h0, base} + 10'(u * 16);
    endfunction

    assign access  = psel && penable;
    assign wr_acc  = access && pwrite;
    assign rd_acc  = access && !pwrite;
    assign index   = paddr[11:2];
    assign aligned = (paddr[1:0] == 2'h0);

    // address decode against unit 0's indices shifted per unit
    always_comb begin
        mapped = 1'b0;
        for (int u = 0; u < units; u++) begin
            hit_low[u]  = aligned && index == unit_index(serial_unit_pkg::idx_unit0_divisor_low, u);
            hit_high[u] = aligned && index == unit_index(serial_unit_pkg::idx_unit0_divisor_high, u);
            hit_lctl[u] = aligned && index == unit_index(serial_unit_pkg::idx_unit0_line_control, u);
            hit_sel[u]  = aligned && index == unit_index(serial_unit_pkg::idx_unit0_controller_select, u);
            hit_stat[u] = aligned && index == unit_index(serial_unit_pkg::idx_unit0_status, u);
            mapped      = mapped | hit_low[u] | hit_high[u] | hit_lctl[u] | hit_sel[u] | hit_stat[u];
        end
    end

    // divisor write restarts the divider only while the access bit is set
    always_comb begin
        for (int u = 0; u < units; u++) begin
            restart[u] = wr_acc && line_control[u][serial_unit_pkg::divisor_access_bit]
                         && (hit_low[u] || hit_high[u]);
            active[u]  = (select_reg[u][1:0] != serial_unit_pkg::sel_none);
        end
    end

    // controller-select: only bits 1:0 writable, upper bits read as zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            select_reg <= {units{serial_unit_pkg::select_reset}};
        end else begin
            for (int u = 0; u < units; u++) begin
                if (wr_acc && hit_sel[u]) begin
                    select_reg[u] <= {6'h00, pwdata[1:0]};
                end
            end
        end
    end

    // line control register; bit 7 steers the shared addresses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_control <= {units{serial_unit_pkg::line_control_reset}};
        end else begin
            for (int u = 0; u < units; u++) begin
                if (wr_acc && hit_lctl[u]) begin
                    line_control[u] <= pwdata[7:0];
                end
            end
        end
    end

    // divisor bytes: writes ignored while access bit is clear (they go to the uart)
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            divisor <= {units{serial_unit_pkg::divisor_reset}};
        end else begin
            for (int u = 0; u < units; u++) begin
                if (restart[u] && hit_low[u]) begin
                    divisor[u][7:0] <= pwdata[7:0];
                end
                if (restart[u] && hit_high[u]) begin
                    divisor[u][15:8] <= pwdata[7:0];
                end
            end
        end
    end

    // the counter must load the byte being written, so feed it the merged value
    logic [units-1:0][15:0] load_value;             // divisor including this cycle's write
    always_comb begin
        for (int u = 0; u < units; u++) begin
            load_value[u] = divisor[u];
            if (restart[u] && hit_low[u]) begin
                load_value[u][7:0] = pwdata[7:0];
            end
            if (restart[u] && hit_high[u]) begin
                load_value[u][15:8] = pwdata[7:0];
            end
        end
    end

    // one divider per unit
    for (genvar g = 0; g < units; g++) begin : g_div
        baud_divider #(
            .width   (16)
        ) u_div (
            .pclk    (pclk),
            .presetn (presetn),
            .active  (active[g]),
            .restart (restart[g]),
            .divisor (load_value[g]),
            .count   (count[g]),
            .tick    (tick[g])
        );
    end

    // controller enables: one-hot from the select field, tick only to spi/uart
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enables <= '0;
        end else begin
            for (int u = 0; u < units; u++) begin
                enables[u].uart_en   <= (select_reg[u][1:0] == serial_unit_pkg::sel_uart);
                enables[u].spi_en    <= (select_reg[u][1:0] == serial_unit_pkg::sel_spi);
                enables[u].twi_en    <= (select_reg[u][1:0] == serial_unit_pkg::sel_twi);  // runs on pclk
                enables[u].baud_tick <= tick[u] && (select_reg[u][1:0] == serial_unit_pkg::sel_uart
                                        || select_reg[u][1:0] == serial_unit_pkg::sel_spi);
            end
        end
    end

    // shared-address strobes pass to the uart when the access bit is clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            uart_buf_wr <= '0;
            uart_buf_rd <= '0;
            uart_ier_wr <= '0;
            uart_wdata  <= 8'h00;
        end else begin
            uart_wdata <= pwdata[7:0];
            for (int u = 0; u < units; u++) begin
                uart_buf_wr[u] <= wr_acc && hit_low[u]  && !line_control[u][serial_unit_pkg::divisor_access_bit];
                uart_buf_rd[u] <= rd_acc && hit_low[u]  && !line_control[u][serial_unit_pkg::divisor_access_bit];
                uart_ier_wr[u] <= wr_acc && hit_high[u] && !line_control[u][serial_unit_pkg::divisor_access_bit];
            end
        end
    end

    // read mux: the access bit picks divisor byte or uart register
    logic [31:0] next_prdata;                       // read value for this access
    always_comb begin
        next_prdata = 32'h0000_0000;
        for (int u = 0; u < units; u++) begin
            if (hit_low[u]) begin
                next_prdata[7:0] = line_control[u][serial_unit_pkg::divisor_access_bit]
                                   ? divisor[u][7:0] : uart_rdata_buf[u];
            end
            if (hit_high[u]) begin
                next_prdata[7:0] = line_control[u][serial_unit_pkg::divisor_access_bit]
                                   ? divisor[u][15:8] : uart_rdata_ier[u];
            end
            if (hit_lctl[u]) begin
                next_prdata[7:0] = line_control[u];
            end
            if (hit_sel[u]) begin
                next_prdata[7:0] = {6'h00, select_reg[u][1:0]};
            end
            if (hit_stat[u]) begin
                next_prdata[15:0] = count[u]; // live divider count
            end
        end
    end

    // apb answer: registered ready, already high in the first access cycle, zero wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && !penable;            // set from the setup cycle, so high in the first access cycle
            pslverr <= psel && !penable && !mapped; // unmapped or misaligned address
            prdata  <= (psel && !penable && !pwrite) ? next_prdata : prdata;
        end
    end

    AST_ONE_HOT_ENABLE: assert property (@(posedge pclk) disable iff (!presetn)
        $onehot0({enables[0].spi_en, enables[0].uart_en, enables[0].twi_en}))
        else $error("more than one controller enabled");

    AST_DIVISOR_LOCKED: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && hit_low[0] && !line_control[0][7]) |=> divisor[0] == $past(divisor[0]) && uart_buf_wr[0])
        else $error("divisor changed while access bit clear");

    AST_WRITE_RELOADS: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && hit_high[0] && line_control[0][7]) |=> count[0][15:8] == $past(pwdata[7:0]))
        else $error("divisor write did not reload counter");

    AST_NO_TICK_UNSELECTED: assert property (@(posedge pclk) disable iff (!presetn)
        (select_reg[0][1:0] == 2'h0) [*2] |=> !enables[0].baud_tick && !enables[0].uart_en)
        else $error("unit ran while deselected");

endmodule

// *** tb/serial_far_side.sv ***
/*
 * behavioural far side of both serial units: uart register contents behind the
 * shared addresses and a counter of baud pulses per unit.
 * assumes the block's strobes are one-cycle pulses on pclk and uart_wdata is valid with them.
 */
`timescale 1ns/10ps
module serial_far_side #(
    parameter int units = 2                                    // serial units watched
) (
    input  wire logic                                    pclk,      // system clock
    input  wire logic                                    presetn,   // async reset, active low
    input  wire logic [units-1:0]                        buf_wr,    // transmit holding write
    input  wire logic [units-1:0]                        ier_wr,    // interrupt enable write
    input  wire logic [7:0]                              wdata,     // byte for the strobes
    input  serial_unit_pkg::unit_enables_t [units-1:0]   en,        // per-unit enables
    output logic      [units-1:0][7:0]                   rdata_buf, // receive buffer contents
    output logic      [units-1:0][7:0]                   rdata_ier, // interrupt enable contents
    output logic      [units-1:0][15:0]                  ticks      // baud pulses seen
);
    // uart registers; transmit loops back into receive so reads show the last write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_buf <= '0;
            rdata_ier <= '0;
        end else begin
            for (int u = 0; u < units; u++) begin
                if (buf_wr[u]) begin
                    rdata_buf[u] <= wdata;
                end
                if (ier_wr[u]) begin
                    rdata_ier[u] <= wdata;
                end
            end
        end
    end

    // every high cycle is one clock enable for the uart/spi side, so a wide pulse counts once per high cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ticks <= '0;
        end else begin
            for (int u = 0; u < units; u++) begin
                if (en[u].baud_tick) begin
                    ticks[u] <= ticks[u] + 16'h0001;
                end
            end
        end
    end
endmodule

// *** tb/tb.sv ***
/*
 * self-checking bench for the serial unit select and baud divider block.
 * assumes an apb slave answering wait-free and byte address = 4 * register index.
 */
`timescale 1ns/10ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin mismatches++; \
    $display("[FAIL] %0t got %h expected %h", $time, got, exp); end end
module tb;
    logic                                  pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0]                           paddr;       // apb byte address
    logic [31:0]                           pwdata, prdata, rd;
    logic [1:0][7:0]                       rbuf, rier;  // far side register contents
    logic [1:0]                            bwr, brd, iwr;
    logic [7:0]                            wdata;
    serial_unit_pkg::unit_enables_t [1:0]  en;          // per-unit enables
    logic [1:0][15:0]                      ticks;       // baud pulses per unit
    logic [15:0]                           t0;          // tick count at window start
    logic [2:0]                            exp_en [4];  // {spi,uart,twi} per select code
    int                                    mismatches, checks_done, cycles;

    serial_unit_select #(.units(2)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .uart_rdata_buf(rbuf), .uart_rdata_ier(rier), .uart_buf_wr(bwr),
        .uart_buf_rd(brd), .uart_ier_wr(iwr), .uart_wdata(wdata), .enables(en));
    serial_far_side #(.units(2)) far (.pclk(pclk), .presetn(presetn), .buf_wr(bwr), .ier_wr(iwr),
        .wdata(wdata), .en(en), .rdata_buf(rbuf), .rdata_ier(rier), .ticks(ticks));

    // clock; a 10 ns period
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // one apb transfer; waits an edge first so psel is never reassigned in one step
    task automatic apb_xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd      = prdata;
        er      = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        apb_xfer(1'b1, idx, wd);
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
        apb_xfer(1'b0, idx, 32'h0);
        `CHK(rd, exp)
    endtask

    // pulses of unit u over n cycles
    task automatic tick_window(input int u, input int n, input logic [15:0] exp);
        t0 = ticks[u];
        repeat (n) @(posedge pclk);
        `CHK(16'(ticks[u] - t0), exp)
    endtask

    // reset state: nothing selected, divider frozen
    task automatic t_reset;
        rdchk(serial_unit_pkg::idx_unit0_controller_select, 32'h0);
        rdchk(serial_unit_pkg::idx_unit1_controller_select, 32'h0);
        rdchk(serial_unit_pkg::idx_unit0_line_control, 32'h0);
        rdchk(serial_unit_pkg::idx_unit0_status, 32'h2);
        tick_window(0, 30, 16'h0);
        `CHK(en, 8'h00)
    endtask

    // every select code, reserved bits read-only
    task automatic t_select;
        for (int s = 0; s < 4; s++) begin
            wr(serial_unit_pkg::idx_unit0_controller_select, 32'(s));
            repeat (3) @(posedge pclk);
            `CHK({en[0].spi_en, en[0].uart_en, en[0].twi_en}, exp_en[s])
            `CHK({en[1].spi_en, en[1].uart_en, en[1].twi_en}, 3'b000)
        end
        wr(serial_unit_pkg::idx_unit0_controller_select, 32'hff);
        rdchk(serial_unit_pkg::idx_unit0_controller_select, 32'h3);
        tick_window(0, 10, 16'h0);
        wr(serial_unit_pkg::idx_unit0_controller_select, 32'h1);
    endtask

    // divisor access, reload period, restart on write, high:low readback
    task automatic t_divisor;
        wr(serial_unit_pkg::idx_unit0_line_control, 32'h80);
        rdchk(serial_unit_pkg::idx_unit0_divisor_low, 32'h2);
        rdchk(serial_unit_pkg::idx_unit0_divisor_high, 32'h0);
        tick_window(0, 40, 16'd20);
        wr(serial_unit_pkg::idx_unit0_divisor_low, 32'h5);
        repeat (4) @(posedge pclk);
        tick_window(0, 50, 16'd10);
        wr(serial_unit_pkg::idx_unit0_divisor_high, 32'h1);
        apb_xfer(1'b0, serial_unit_pkg::idx_unit0_status, 32'h0);
        `CHK(1'(rd[15:0] > 16'h00f0 && rd[15:0] <= 16'h0105), 1'b1)
        rdchk(serial_unit_pkg::idx_unit0_divisor_high, 32'h1);
        rdchk(serial_unit_pkg::idx_unit0_divisor_low, 32'h5);
        wr(serial_unit_pkg::idx_unit0_divisor_high, 32'h0);
        wr(serial_unit_pkg::idx_unit0_line_control, 32'h0);
    endtask

    // with the access bit clear the shared addresses reach the uart
    task automatic t_shared;
        wr(serial_unit_pkg::idx_unit0_divisor_low, 32'h5a);
        repeat (3) @(posedge pclk);
        `CHK(rbuf[0], 8'h5a)
        rdchk(serial_unit_pkg::idx_unit0_divisor_low, 32'h5a);
        @(posedge pclk);
        `CHK(brd, 2'h1)
        wr(serial_unit_pkg::idx_unit0_divisor_high, 32'h3c);
        rdchk(serial_unit_pkg::idx_unit0_divisor_high, 32'h3c);
        wr(serial_unit_pkg::idx_unit0_line_control, 32'h80);
        rdchk(serial_unit_pkg::idx_unit0_divisor_low, 32'h5);
        @(posedge pclk);
        `CHK(brd, 2'h0)
        wr(serial_unit_pkg::idx_unit0_line_control, 32'h0);
    endtask

    // second unit on its reset divisor, then an unmapped address
    task automatic t_unit1_unmapped;
        wr(serial_unit_pkg::idx_unit1_controller_select, 32'h2);
        repeat (3) @(posedge pclk);
        `CHK({en[1].spi_en, en[1].uart_en, en[1].twi_en}, 3'b100)
        tick_window(1, 40, 16'd20);
        wr(serial_unit_pkg::idx_unit1_controller_select, 32'h0);
        // odd spacing between the two samples so a running period-2 count would differ
        apb_xfer(1'b0, serial_unit_pkg::idx_unit1_status, 32'h0);
        t0 = rd[15:0];
        repeat (2) @(posedge pclk);
        rdchk(serial_unit_pkg::idx_unit1_status, {16'h0, t0});
        apb_xfer(1'b0, 8'h00, 32'h0);
        `CHK({er, rd}, {1'b1, 32'h0})
    endtask

    task automatic final_report;
        $display("mismatches %0d checks_done %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // hang guard: the sequence needs well under a thousand cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            $display("[FAIL] %0t timeout", $time);
            final_report();
        end
    end

    // main sequence
    initial begin
        exp_en = '{3'b000, 3'b010, 3'b100, 3'b001};
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        mismatches = 0;
        checks_done = 0;
        cycles = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_select();
        t_divisor();
        t_shared();
        t_unit1_unmapped();
        final_report();
    end
endmodule
